// ---- rtl/ioc_osc_ctrl.sv ----
`timescale 1ns/10ps
module ioc_osc_ctrl
  import ioc_pkg::*;
#(
  parameter int SETTLE_CYCLES = IOC_SETTLE_CYCLES,
  parameter int SYNC_TCLKS = IOC_SYNC_TCLKS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // special-function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // suspend wake and timer
  input wire logic wake_any_i,
  input wire logic wake_from_timer_i,
  input wire logic timer_clk_i,
  // external oscillator context
  input wire logic [2:0] ext_mode_i,
  input wire logic [2:0] core_system_clock_source_select_i,
  // oscillator controls
  output logic hf_osc_run_o,
  output logic [3:0] hf_post_div_o,
  output logic signed [3:0] dither_trim_o,
  output logic sel_ext_o,
  output logic sel_int_o,
  output logic crystal_in_pin_claim_o,
  output logic crystal_out_pin_claim_o
);
  import ioc_pkg::*;
  logic hf_osc_enable_bit_q;
  logic suspend_q;
  logic spread_dither_enable_q;
  logic [1:0] hf_post_divider_select_q;
  logic hf_freq_ready_flag_q;
  logic suspend_timer_sync_flag_q;
  logic [7:0] settle_q;
  logic [1:0] sync_cnt_q;
  logic wake_s1_q, wake_s2_q, wtmr_s1_q, wtmr_s2_q, tclk_s1_q, tclk_s2_q, tclk_d_q;
  logic ctrl_wr;
  logic wake_evt;
  logic wake_d_q;
  logic tclk_rise;
  logic ready_read;

  function automatic logic [3:0] div_ratio(input logic [1:0] sel);
    unique case (sel)
      2'h0: div_ratio = 4'h8;
      2'h1: div_ratio = 4'h4;
      2'h2: div_ratio = 4'h2;
      2'h3: div_ratio = 4'h1;
    endcase
  endfunction

  assign ctrl_wr = sfr_wr_i && (sfr_addr_i == IOC_CTRL_ADDR);

  // pin synchronisers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wtmr_s1_q <= 1'b0;
      wtmr_s2_q <= 1'b0;
      tclk_s1_q <= 1'b0;
      tclk_s2_q <= 1'b0;
      tclk_d_q <= 1'b0;
      wake_d_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_any_i;
      wake_s2_q <= wake_s1_q;
      wtmr_s1_q <= wake_from_timer_i;
      wtmr_s2_q <= wtmr_s1_q;
      tclk_s1_q <= timer_clk_i;
      tclk_s2_q <= tclk_s1_q;
      tclk_d_q <= tclk_s2_q;
      wake_d_q <= wake_s2_q;
    end
  end
  assign wake_evt = wake_s2_q && !wake_d_q;
  assign tclk_rise = tclk_s2_q && !tclk_d_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hf_osc_enable_bit_q <= IOC_EN_RESET;
      spread_dither_enable_q <= 1'b0;
      hf_post_divider_select_q <= IOC_DIV_RESET;
    end else if (ctrl_wr) begin
      hf_osc_enable_bit_q <= sfr_wdata_i[IOC_EN_BIT];
      spread_dither_enable_q <= sfr_wdata_i[IOC_DITHER_BIT];
      hf_post_divider_select_q <= sfr_wdata_i[1:0];
    end
  end

  // suspend and wake; wake wins over a write
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      suspend_q <= 1'b0;
    end else if (wake_evt) begin
      suspend_q <= 1'b0;
    end else if (ctrl_wr && sfr_wdata_i[IOC_SUSP_BIT]) begin
      suspend_q <= 1'b1;
    end
  end

  assign hf_osc_run_o = hf_osc_enable_bit_q && !suspend_q;
  // stopped reads not ready at once
  assign ready_read = hf_freq_ready_flag_q && hf_osc_run_o;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      settle_q <= 8'h00;
      hf_freq_ready_flag_q <= 1'b1;
    end else if (!hf_osc_run_o || (ctrl_wr && sfr_wdata_i[1:0] != hf_post_divider_select_q)) begin
      settle_q <= 8'(SETTLE_CYCLES);
      hf_freq_ready_flag_q <= 1'b0;
    end else if (settle_q != 8'h00) begin
      settle_q <= settle_q - 8'h01;
      hf_freq_ready_flag_q <= 1'b0;
    end else begin
      hf_freq_ready_flag_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      suspend_timer_sync_flag_q <= 1'b0;
      sync_cnt_q <= 2'h0;
    end else if (wake_evt && suspend_q && !wtmr_s2_q) begin
      suspend_timer_sync_flag_q <= 1'b1;
      sync_cnt_q <= 2'(SYNC_TCLKS);
    end else if (suspend_timer_sync_flag_q && tclk_rise) begin
      if (sync_cnt_q == 2'h1) begin
        suspend_timer_sync_flag_q <= 1'b0;
      end
      sync_cnt_q <= sync_cnt_q - 2'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i && sfr_addr_i == IOC_CTRL_ADDR) begin
      sfr_rdata_o <= {hf_osc_enable_bit_q, ready_read, suspend_q,
                      suspend_timer_sync_flag_q, spread_dither_enable_q, 1'b0,
                      hf_post_divider_select_q};
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hf_post_div_o <= 4'h8;
    end else begin
      hf_post_div_o <= div_ratio(hf_post_divider_select_q);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sel_int_o <= 1'b1;
      sel_ext_o <= 1'b0;
    end else begin
      sel_int_o <= core_system_clock_source_select_i == IOC_SRC_INT;
      sel_ext_o <= core_system_clock_source_select_i == IOC_SRC_EXT;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      crystal_in_pin_claim_o <= 1'b0;
      crystal_out_pin_claim_o <= 1'b0;
    end else begin
      crystal_in_pin_claim_o <= ext_mode_i == IOC_XMODE_XTAL || ext_mode_i == IOC_XMODE_XTAL_DIV2;
      crystal_out_pin_claim_o <= ext_mode_i != IOC_XMODE_OFF && ext_mode_i != IOC_XMODE_RSVD;
    end
  end

  ioc_dither u_dither (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .enable_i(spread_dither_enable_q && hf_osc_run_o),
    .trim_o(dither_trim_o)
  );
endmodule

// ---- rtl/ioc_pkg.sv ----
package ioc_pkg;
  localparam logic [7:0] IOC_CTRL_ADDR = 8'h00_b2;
  localparam int IOC_EN_BIT = 7;
  localparam int IOC_RDY_BIT = 6;
  localparam int IOC_SUSP_BIT = 5;
  localparam int IOC_SYNC_BIT = 4;
  localparam int IOC_DITHER_BIT = 3;
  localparam int IOC_UNUSED_BIT = 2;
  localparam logic [1:0] IOC_DIV_RESET = 2'h0;
  localparam logic IOC_EN_RESET = 1'b1;
  // dither: triangle period 384 osc cycles, step every 32
  localparam int IOC_TRI_PERIOD = 384;
  localparam int IOC_STEP_CYCLES = 32;
  localparam int IOC_TRI_STEPS = IOC_TRI_PERIOD / IOC_STEP_CYCLES;
  localparam int IOC_SYNC_TCLKS = 3;
  localparam int IOC_SETTLE_CYCLES = 4;
  localparam logic [2:0] IOC_SRC_INT = 3'h0;
  localparam logic [2:0] IOC_SRC_EXT = 3'h1;
  // external oscillator mode field codes
  localparam logic [2:0] IOC_XMODE_OFF = 3'h0;
  localparam logic [2:0] IOC_XMODE_RSVD = 3'h1;
  localparam logic [2:0] IOC_XMODE_CMOS = 3'h2;
  localparam logic [2:0] IOC_XMODE_CMOS2 = 3'h3;
  localparam logic [2:0] IOC_XMODE_RC = 3'h4;
  localparam logic [2:0] IOC_XMODE_CAP = 3'h5;
  localparam logic [2:0] IOC_XMODE_XTAL = 3'h6;
  localparam logic [2:0] IOC_XMODE_XTAL_DIV2 = 3'h7;
endpackage

// ---- rtl/ioc_dither.sv ----
`timescale 1ns/10ps
module ioc_dither
  import ioc_pkg::*;
#(
  parameter int STEP_CYCLES = IOC_STEP_CYCLES,
  parameter int TRI_STEPS = IOC_TRI_STEPS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // control
  input wire logic enable_i,
  // signed frequency trim step
  output logic signed [3:0] trim_o
);
  import ioc_pkg::*;
  localparam int HALF = TRI_STEPS / 2;
  logic [7:0] cyc_q;
  logic [3:0] step_q;
  logic up_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i || !enable_i) begin
      cyc_q <= 8'h00;
    end else if (cyc_q == 8'(STEP_CYCLES - 1)) begin
      cyc_q <= 8'h00;
    end else begin
      cyc_q <= cyc_q + 8'h01;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i || !enable_i) begin
      step_q <= 4'(HALF / 2);
      up_q <= 1'b1;
    end else if (cyc_q == 8'(STEP_CYCLES - 1)) begin
      if (up_q && step_q == 4'(HALF)) begin
        up_q <= 1'b0;
        step_q <= step_q - 4'h1;
      end else if (!up_q && step_q == 4'h0) begin
        up_q <= 1'b1;
        step_q <= step_q + 4'h1;
      end else if (up_q) begin
        step_q <= step_q + 4'h1;
      end else begin
        step_q <= step_q - 4'h1;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i || !enable_i) begin
      trim_o <= 4'sh0;
    end else begin
      trim_o <= $signed(step_q) - $signed(4'(HALF / 2));
    end
  end
endmodule

// ---- verification/ioc_monitor.sv ----
`timescale 1ns/10ps
module ioc_monitor
  import ioc_pkg::*;
(
  // clock, reset, register port, wake input
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic wake_any_i,
  // context and outputs
  input wire logic [2:0] ext_mode_i,
  input wire logic [2:0] core_system_clock_source_select_i,
  input wire logic hf_osc_run_o,
  input wire logic [3:0] hf_post_div_o,
  input wire logic signed [3:0] dither_trim_o,
  input wire logic sel_ext_o,
  input wire logic sel_int_o,
  input wire logic crystal_in_pin_claim_o,
  input wire logic crystal_out_pin_claim_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire ctl_wr = sfr_wr_i && sfr_addr_i == IOC_CTRL_ADDR;
  wire ctl_rd = sfr_rd_i && sfr_addr_i == IOC_CTRL_ADDR;
  div_reset_a: assert property ($past(rst_i) |-> hf_post_div_o == 4'h8)
    else $error("divider not 8 after reset");
  div_write_a: assert property (ctl_wr |-> ##2 hf_post_div_o == (4'h8 >> $past(sfr_wdata_i[1:0], 2)))
    else $error("divider ratio wrong");
  en_off_a: assert property (ctl_wr && !sfr_wdata_i[IOC_EN_BIT] |=> !hf_osc_run_o)
    else $error("oscillator runs while disabled");
  susp_stop_a: assert property (ctl_wr && sfr_wdata_i[IOC_SUSP_BIT]
    && !($past(wake_any_i, 2) && !$past(wake_any_i, 3)) |=> !hf_osc_run_o)
    else $error("oscillator runs after suspend");
  unused_zero_a: assert property ($past(ctl_rd) |-> !sfr_rdata_o[IOC_UNUSED_BIT])
    else $error("unused bit reads one");
  rdy_low_a: assert property ($past(ctl_rd) && !$past(hf_osc_run_o) |-> !sfr_rdata_o[IOC_RDY_BIT])
    else $error("ready set while stopped");
  trim_range_a: assert property (dither_trim_o >= -3 && dither_trim_o <= 3)
    else $error("dither trim out of range");
  src_sel_a: assert property (!$past(rst_i) |-> sel_int_o == ($past(core_system_clock_source_select_i) == IOC_SRC_INT)
    && sel_ext_o == ($past(core_system_clock_source_select_i) == IOC_SRC_EXT)) else $error("source decode wrong");
  xin_claim_a: assert property (!$past(rst_i) |-> crystal_in_pin_claim_o == ($past(ext_mode_i) >= IOC_XMODE_XTAL))
    else $error("input pin claim wrong");
  xout_claim_a: assert property (!$past(rst_i) |-> crystal_out_pin_claim_o == ($past(ext_mode_i) >= IOC_XMODE_CMOS))
    else $error("output pin claim wrong");
  cover property (ctl_wr && sfr_wdata_i[IOC_SUSP_BIT]);
  cover property (ctl_rd ##1 sfr_rdata_o[IOC_SYNC_BIT]);
  cover property (crystal_in_pin_claim_o);
  cover property ($changed(dither_trim_o));
endmodule
bind ioc_osc_ctrl ioc_monitor u_ioc_monitor (.mclk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
  .sfr_wdata_i, .sfr_rdata_o, .wake_any_i, .ext_mode_i, .core_system_clock_source_select_i, .hf_osc_run_o,
  .hf_post_div_o, .dither_trim_o, .sel_ext_o, .sel_int_o, .crystal_in_pin_claim_o, .crystal_out_pin_claim_o);

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import ioc_pkg::*;
  logic mclk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, wake_any_i = 1'b0, wake_from_timer_i = 1'b0;
  logic timer_clk_i = 1'b0, hf_osc_run_o, sel_ext_o, sel_int_o, crystal_in_pin_claim_o, crystal_out_pin_claim_o;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, d;
  logic [2:0] ext_mode_i = 3'h0, core_system_clock_source_select_i = 3'h0;
  logic [3:0] hf_post_div_o;
  logic signed [3:0] dither_trim_o;
  logic [15:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic signed [3:0] tr0, tr_prev, tmin, tmax;
  int nchg;
  int failures = 0, n_checks = 0;
  always #50 mclk_i = ~mclk_i;
  ioc_osc_ctrl u_ioc_osc_ctrl (.mclk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .wake_any_i, .wake_from_timer_i, .timer_clk_i, .ext_mode_i, .core_system_clock_source_select_i,
    .hf_osc_run_o, .hf_post_div_o, .dither_trim_o, .sel_ext_o, .sel_int_o, .crystal_in_pin_claim_o,
    .crystal_out_pin_claim_o);
  task check(input string nm, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // one register access; reads queue the masked expectation
  task acc(input logic w, input logic [7:0] a, v, m);
    cyc(1);
    {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = {w, !w, a, v};
    if (!w) exp_q.push_back({m, v & m});
    cyc(1);
    {sfr_wr_i, sfr_rd_i} = 2'b00;
  endtask
  always @(posedge mclk_i) rd_seen <= sfr_rd_i;
  always @(negedge mclk_i) if (rd_seen) begin
    check("rdata", exp_q[0][7:0], sfr_rdata_o & exp_q[0][15:8]);
    void'(exp_q.pop_front());
  end
  initial begin
    void'($urandom(32'h0cbb));
    cyc(12);
    rst_i = 0;
    acc(0, IOC_CTRL_ADDR, 8'hc0, 8'hff);
    for (int i = 0; i < 4; i++) begin
      acc(1, IOC_CTRL_ADDR, 8'h80 | i[7:0], 8'h00);
      cyc(1);
      check("div", {4'h0, 4'h8 >> i}, {4'h0, hf_post_div_o});
      acc(0, IOC_CTRL_ADDR, 8'h80 | i[7:0], 8'hbf);
    end
    // random settings, suspend kept clear; stray address must not land
    repeat (6) begin
      d = 8'($urandom) & 8'hdf | 8'h80;
      acc(1, IOC_CTRL_ADDR, d, 8'h00);
      acc(1, 8'(IOC_CTRL_ADDR + 1), 8'h00, 8'h00);
      acc(0, IOC_CTRL_ADDR, d & 8'h8b, 8'h8f);
      acc(0, 8'(IOC_CTRL_ADDR + 1), 8'h00, 8'hff);
    end
    acc(1, IOC_CTRL_ADDR, 8'h03, 8'h00);
    cyc(3);
    check("run", 8'h00, 8'(hf_osc_run_o));
    acc(0, IOC_CTRL_ADDR, 8'h03, 8'hcf);
    acc(1, IOC_CTRL_ADDR, 8'ha3, 8'h00);
    check("run", 8'h00, 8'(hf_osc_run_o));
    cyc(3);
    wake_any_i = 1'b1;
    cyc(12);
    wake_any_i = 1'b0;
    check("run", 8'h01, 8'(hf_osc_run_o));
    acc(0, IOC_CTRL_ADDR, 8'hd0, 8'hf0);
    repeat (3) begin
      timer_clk_i = 1'b1;
      cyc(3);
      timer_clk_i = 1'b0;
      cyc(3);
    end
    acc(0, IOC_CTRL_ADDR, 8'h00, 8'h10);
    // timer wake leaves sync flag clear; suspended reads not ready
    acc(1, IOC_CTRL_ADDR, 8'ha0, 8'h00);
    wake_from_timer_i = 1'b1;
    acc(0, IOC_CTRL_ADDR, 8'ha0, 8'he0);
    wake_any_i = 1'b1;
    cyc(6);
    {wake_any_i, wake_from_timer_i} = 2'b00;
    acc(0, IOC_CTRL_ADDR, 8'h80, 8'hb0);
    // dither: one period holds every step and spans half of them
    acc(1, IOC_CTRL_ADDR, 8'h88, 8'h00);
    cyc(40);
    tr0 = dither_trim_o;
    tr_prev = tr0;
    tmin = tr0;
    tmax = tr0;
    nchg = 0;
    repeat (IOC_TRI_PERIOD) begin
      cyc(1);
      if (dither_trim_o != tr_prev) nchg++;
      tr_prev = dither_trim_o;
      if (dither_trim_o < tmin) tmin = dither_trim_o;
      if (dither_trim_o > tmax) tmax = dither_trim_o;
    end
    check("trim period", 8'(tr0), 8'(dither_trim_o));
    check("trim steps", 8'(IOC_TRI_STEPS), 8'(nchg));
    check("trim span", 8'(IOC_TRI_STEPS / 2), 8'(tmax - tmin));
    acc(1, IOC_CTRL_ADDR, 8'h80, 8'h00);
    cyc(2);
    check("trim off", 8'h00, 8'(dither_trim_o));
    for (int m = 0; m < 8; m++) begin
      ext_mode_i = m[2:0];
      core_system_clock_source_select_i = 3'(m + 7);
      cyc(2);
      check("xin", 8'(m >= 6), 8'(crystal_in_pin_claim_o));
      check("xout", 8'(m >= 2), 8'(crystal_out_pin_claim_o));
      check("sel", 8'({m == 1, m == 2}), 8'({sel_int_o, sel_ext_o}));
    end
    // divider back to 8 after a mid-run reset
    acc(1, IOC_CTRL_ADDR, 8'h0b, 8'h00);
    cyc(2);
    check("div", 8'h01, {4'h0, hf_post_div_o});
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    check("div", 8'h08, {4'h0, hf_post_div_o});
    acc(0, IOC_CTRL_ADDR, 8'hc0, 8'hff);
    cyc(4);
    close_out();
  end
  initial begin
    #2000000;
    failures++;
    close_out();
  end
endmodule
